// >>> bench/xcvr_line_model.sv
// Far-side model: remote transceiver feeding the block's line side.
// Assumes the bench raises send for one cycle per word, at falling edges.
`timescale 1ns/1ps
module xcvr_line_model (
  // Clock and request from the bench
  input  wire logic        sys_clk,
  input  wire logic        send,
  input  wire logic [15:0] word,
  // Toward the block
  output logic             line_rx_valid,
  output logic [15:0]      line_rx_data,
  output logic             serial_bit
);
  logic        send_q = 1'b0;
  logic [15:0] word_q = 16'h0000;
  // Requests are taken at the rising edge, so the bench's falling-edge
  // update never races the drive below; this costs one cycle of latency
  always @(posedge sys_clk)
  begin
    send_q <= send;
    word_q <= word;
  end
  // Idle data flips every cycle so a stale word never passes as fresh
  initial
  begin
    line_rx_valid = 1'b0;
    line_rx_data  = 16'h0000;
    serial_bit    = 1'b0;
  end
  always @(negedge sys_clk)
  begin
    line_rx_valid <= send_q;
    line_rx_data  <= send_q ? word_q : ~line_rx_data;
    serial_bit    <= ~serial_bit; // Toggling bit exposes a stuck pin
  end
endmodule

// >>> bench/xcvr_loop_ctrl_bench.sv
// Bench: directed tests of loopback modes, directional resets, sleep and FIFO.
// Assumes the line model as far side; inputs change at falling edges.
`timescale 1ns/1ps
module xcvr_loop_ctrl_bench
  import xcvr_ctrl_pkg::*;
;
  logic sys_clk = 1'b0, sys_rst = 1'b1, send = 1'b0, k;
  loopback_mode_t loopback_sel = LB_NORMAL;
  logic tx_side_reset = 0, rx_side_reset = 0, tx_output_inhibit = 0, transceiver_sleep = 0;
  logic package_power_down = 0, analog_cfg_load = 0, tx_valid = 0, rx_ready = 0;
  logic [7:0] analog_cfg_in = 8'h00, analog_cfg;
  logic [15:0] tx_data = 16'h0000, word = 16'h0000, rx_data, line_rx_data, line_tx_data;
  logic tx_ready, rx_valid, line_rx_valid, serial_out_pos, serial_out_pos_oe;
  logic serial_out_neg_oe, serial_loop_en, serial_bit, tx_in_reset, rx_in_reset, sleeping;
  logic serial_out_neg;
  int bad_count = 0, n_compared = 0, cycles = 0, n;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  xcvr_loop_ctrl u_dut (.sys_clk, .sys_rst, .loopback_sel, .tx_side_reset, .rx_side_reset,
    .tx_output_inhibit, .transceiver_sleep, .package_power_down, .analog_cfg_in,
    .analog_cfg_load, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
    .line_rx_data, .line_rx_valid, .line_tx_data, .serial_out_pos, .serial_out_neg,
    .serial_out_pos_oe, .serial_out_neg_oe, .serial_loop_en, .serial_bit, .tx_in_reset,
    .rx_in_reset, .sleeping, .analog_cfg, .analog_pipe_tick());
  xcvr_line_model u_line (.sys_clk, .send, .word, .line_rx_valid, .line_rx_data, .serial_bit);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge sys_clk);
  endtask
  // Transmit word held until the edge that finds the FIFO ready
  task automatic push(input logic [15:0] w);
    tx_valid = 1'b1;
    tx_data  = w;
    while (tx_ready !== 1'b1) cyc(1);
    cyc(1);
    tx_valid = 1'b0;
  endtask
  task automatic line(input logic [15:0] w);
    send = 1'b1;
    word = w;
    cyc(1);
    send = 1'b0;
  endtask
  // Bounded waits; the final compare reports a word that never showed
  task automatic rx_expect(input logic [15:0] w);
    for (int i = 0; i < 8 && rx_valid !== 1'b1; i++) cyc(1);
    chk("rx_data", w, rx_valid === 1'b1 ? rx_data : ~w);
    rx_ready = 1'b1;
    cyc(1);
    rx_ready = 1'b0;
  endtask
  task automatic wait_tx(input logic [15:0] w);
    for (int i = 0; i < 8 && line_tx_data !== w; i++) cyc(1);
    chk("line_tx_data", w, line_tx_data);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, far above the hundred or so cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      complete_run();
    end
  end
  initial
  begin
    cyc(12);
    sys_rst = 1'b0;
    package_power_down = 1'b1;
    cyc(6);
    chk("tx_in_reset", 0, tx_in_reset);
    chk("serial_loop_en", 0, serial_loop_en);
    $display("test reset done");
    // Sleep stalls the transmit FIFO: fill it until it refuses
    analog_cfg_in = 8'h5a;
    analog_cfg_load = 1'b1;
    transceiver_sleep = 1'b1;
    cyc(1);
    analog_cfg_load = 1'b0;
    tx_valid = 1'b1;
    for (n = 0; n < 20 && tx_ready === 1'b1; n++)
    begin
      tx_data = 16'h0100 + 16'(n);
      cyc(1);
    end
    tx_valid = 1'b0;
    chk("fill_count", 16, 16'(n));
    transceiver_sleep = 1'b0;
    for (int i = 0; i < 16; i++) wait_tx(16'h0100 + 16'(i));
    chk("pos_oe", 1, serial_out_pos_oe);
    chk("sleeping", 0, sleeping);
    $display("test buffer done");
    // Transmit reset drops a stored word and clears the encoder
    transceiver_sleep = 1'b1;
    push(16'h0aa1);
    tx_side_reset = 1'b1;
    cyc(2);
    chk("line_tx_data", 0, line_tx_data);
    tx_side_reset = 1'b0;
    transceiver_sleep = 1'b0;
    cyc(8);
    chk("line_tx_data", 0, line_tx_data);
    $display("test tx reset done");
    line(16'h1234);
    rx_expect(16'h1234);
    rx_side_reset = 1'b1;
    line(16'h5555);
    cyc(3);
    chk("rx_valid", 0, rx_valid);
    rx_side_reset = 1'b0;
    cyc(6);
    chk("rx_in_reset", 0, rx_in_reset);
    chk("analog_cfg", 8'h5a, analog_cfg);
    line(16'h0f0f);
    rx_expect(16'h0f0f);
    $display("test rx reset done");
    // Select codes 0 to 5, the five valid ones and invalid code 5; code 5 keeps repeater
    for (int m = 0; m < 6; m++)
    begin
      loopback_sel = loopback_mode_t'(m);
      cyc(2);
      chk("serial_loop_en", m == 1 || m == 2, serial_loop_en);
      chk("pos_oe", m != 1, serial_out_pos_oe);
    end
    loopback_sel = LB_PARALLEL;
    cyc(2);
    push(16'h3c3c);
    rx_expect(16'h3c3c);
    loopback_sel = LB_REPEATER;
    cyc(2);
    line(16'h6b6b);
    wait_tx(16'h6b6b);
    chk("rx_valid", 0, rx_valid);
    chk("tx_ready", 0, tx_ready);
    loopback_sel = LB_NORMAL;
    $display("test modes done");
    // Inhibit holds the positive pin low; a toggling bit shows release
    tx_output_inhibit = 1'b1;
    k = 1'b0;
    repeat (4)
    begin
      cyc(1);
      k = k | serial_out_pos;
    end
    chk("pos_inhibited", 0, k);
    chk("serial_out_neg", !serial_bit, serial_out_neg);
    tx_output_inhibit = 1'b0;
    k = 1'b0;
    repeat (3)
    begin
      cyc(1);
      k = k | serial_out_pos;
    end
    chk("pos_released", 1, k);
    $display("test inhibit done");
    complete_run();
  end
endmodule

// >>> bench/xcvr_loop_ctrl_checker.sv
// Checker: port assertions for the loopback and reset control block.
// Assumes one clock, sys_clk, and the asynchronous reset sys_rst.
`timescale 1ns/1ps
module xcvr_loop_ctrl_checker
  import xcvr_ctrl_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int CFG_W  = CFG_W_DEF
)(
  // Clock, reset and controls
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire loopback_mode_t    loopback_sel,
  input wire logic              tx_side_reset,
  input wire logic              rx_side_reset,
  input wire logic              tx_output_inhibit,
  input wire logic              transceiver_sleep,
  input wire logic              analog_cfg_load,
  // Line side and pins
  input wire logic              line_rx_valid,
  input wire logic [DATA_W-1:0] line_rx_data,
  input wire logic [DATA_W-1:0] line_tx_data,
  input wire logic              serial_out_pos,
  input wire logic              serial_out_pos_oe,
  input wire logic              serial_out_neg_oe,
  input wire logic              serial_loop_en,
  // Status
  input wire logic              tx_in_reset,
  input wire logic              rx_in_reset,
  input wire logic              sleeping,
  input wire logic [CFG_W-1:0]  analog_cfg,
  input wire logic              analog_pipe_tick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Mode checks look one edge after the select, since the mode is registered
  a_inhibit_pos_low: assert property (tx_output_inhibit |-> !serial_out_pos)
    else $error("positive pin high while inhibited");
  a_pre_pins_off: assert property (loopback_sel == LB_SERIAL_PRE |=>
    !serial_out_pos_oe && !serial_out_neg_oe) else $error("pins driven in pre loop");
  a_post_pins_on: assert property (loopback_sel == LB_SERIAL_POST ##1
    !transceiver_sleep |-> serial_out_pos_oe && serial_out_neg_oe && serial_loop_en)
    else $error("post loop pins or loop wrong");
  a_par_loop_off: assert property (loopback_sel == LB_PARALLEL ##1
    !transceiver_sleep |-> !serial_loop_en && serial_out_pos_oe && serial_out_neg_oe)
    else $error("parallel loop pins or loop wrong");
  a_tx_reset_hold: assert property (tx_side_reset |-> tx_in_reset)
    else $error("transmit not in reset");
  // Release takes exactly five edges in each direction
  a_tx_release_five: assert property ($fell(tx_side_reset) |->
    tx_in_reset [*5] ##1 !tx_in_reset) else $error("transmit release count wrong");
  a_rx_release_five: assert property ($fell(rx_side_reset) |->
    rx_in_reset [*5] ##1 !rx_in_reset) else $error("receive release count wrong");
  a_sleep_pins_off: assert property (transceiver_sleep [*2] |->
    sleeping && !serial_out_pos_oe && !serial_out_neg_oe) else $error("sleep not applied");
  a_cfg_held: assert property ((tx_side_reset || rx_side_reset) && !analog_cfg_load
    |=> $stable(analog_cfg)) else $error("analog config changed in reset");
  a_pipe_alive: assert property ((tx_side_reset || rx_side_reset) && !transceiver_sleep
    |=> analog_pipe_tick != $past(analog_pipe_tick)) else $error("analog pipe stopped");
  a_repeat_direct: assert property (loopback_sel == LB_REPEATER ##1
    (loopback_sel == LB_REPEATER && line_rx_valid) |=> line_tx_data == $past(line_rx_data))
    else $error("repeater word not forwarded");
endmodule
bind xcvr_loop_ctrl xcvr_loop_ctrl_checker #(.DATA_W(DATA_W), .CFG_W(CFG_W)) u_chk (
  .sys_clk, .sys_rst, .loopback_sel, .tx_side_reset, .rx_side_reset, .tx_output_inhibit,
  .transceiver_sleep, .analog_cfg_load, .line_rx_valid, .line_rx_data, .line_tx_data,
  .serial_out_pos, .serial_out_pos_oe, .serial_out_neg_oe, .serial_loop_en,
  .tx_in_reset, .rx_in_reset, .sleeping, .analog_cfg, .analog_pipe_tick
);

// >>> src/xcvr_ctrl_pkg.sv
// Package for the transceiver loopback and reset control block.
// Assumes a single 25 MHz system clock; shared constants and types live here.
package xcvr_ctrl_pkg;

  // Loopback selection, normal operation is the reset value
  typedef enum logic [2:0] {
    LB_NORMAL,
    LB_SERIAL_PRE,
    LB_SERIAL_POST,
    LB_PARALLEL,
    LB_REPEATER
  } loopback_mode_t;

  localparam int DATA_W_DEF      = 16;
  localparam int FIFO_DEPTH_DEF  = 16;
  localparam int RESET_HOLD_CLKS = 5;    // Clocks to leave reset per domain
  localparam int CFG_W_DEF       = 8;
  localparam logic [2:0] HOLD_ZERO = 3'h0;
  localparam logic [2:0] HOLD_DONE = 3'h5;

  // Word carried along a data path
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } beat_t;

  // Serial line state toward the pins and loopback taps
  typedef struct packed {
    logic pos;
    logic neg;
    logic pos_oe;
    logic neg_oe;
  } serial_pins_t;

endpackage

// >>> src/xcvr_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; flush empties it (used as recentring on reset).
`timescale 1ns/1ps
module xcvr_fifo
  import xcvr_ctrl_pkg::*;
#(
  parameter int WIDTH = DATA_W_DEF,
  parameter int DEPTH = FIFO_DEPTH_DEF
)(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push;
  wire              pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // Storage write
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  // Pointers and count; flush recentres to empty
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else if (flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> src/xcvr_loop_ctrl.sv
// Loopback, directional reset and sleep control for a serial transceiver.
// Assumes the serializer sits outside; its parallel words arrive on sys_clk.
`timescale 1ns/1ps

// Notes on behaviour
// - Four test loopbacks: serial pre-driver, serial post-driver, parallel, repeater.
// - Pre-driver loopback feeds transmit to receiver and leaves both serial pins undriven.
// - Post-driver loopback keeps both serial pins driven while looping back.
// - Parallel loopback disables serial loop path; transmitter outputs stay active.
// - Inhibit holds the positive serial output at 0 until released.
// - Repeater loopback retransmits received data without passing the user side.
// - Transmit reset recentres transmit FIFO, clears transmit registers and encoder.
// - Receive reset recentres receive buffer, clears receive registers and decoder.
// - Both resets active high; each direction's coding layer in reset while its own reset is high.
// - After release, five clocks per affected domain before leaving reset.
// - Directional resets leave the analogue configuration vector unchanged.
// - Analogue pipeline keeps running during a directional reset.
// - Power-down follows the transceiver sleep input.
// - Package power-down pin has no effect on the transceiver unit.
module xcvr_loop_ctrl
  import xcvr_ctrl_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int DEPTH  = FIFO_DEPTH_DEF,
  parameter int CFG_W  = CFG_W_DEF
)(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // Control
  input  wire loopback_mode_t    loopback_sel,
  input  wire logic              tx_side_reset,
  input  wire logic              rx_side_reset,
  input  wire logic              tx_output_inhibit,
  input  wire logic              transceiver_sleep,
  input  wire logic              package_power_down,
  input  wire logic [CFG_W-1:0]  analog_cfg_in,
  input  wire logic              analog_cfg_load,
  // User transmit stream
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic [DATA_W-1:0] tx_data,
  // User receive stream
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output logic [DATA_W-1:0]      rx_data,
  // Line side, parallel words from and to the serializer
  input  wire logic [DATA_W-1:0] line_rx_data,
  input  wire logic              line_rx_valid,
  output logic [DATA_W-1:0]      line_tx_data,
  // Serial pins and loopback tap
  output logic                   serial_out_pos,
  output logic                   serial_out_neg,
  output logic                   serial_out_pos_oe,
  output logic                   serial_out_neg_oe,
  output logic                   serial_loop_en,
  input  wire logic              serial_bit,
  // Status
  output logic                   tx_in_reset,
  output logic                   rx_in_reset,
  output logic                   sleeping,
  output logic [CFG_W-1:0]       analog_cfg,
  output logic                   analog_pipe_tick
);

  logic [2:0]        tx_hold_reg;
  logic [2:0]        rx_hold_reg;
  logic [DATA_W-1:0] enc_reg;
  logic [DATA_W-1:0] dec_reg;
  logic              dec_valid_reg;
  logic [CFG_W-1:0]  cfg_reg;
  logic              pipe_reg;
  logic              pos_reg;
  logic              neg_reg;
  loopback_mode_t    mode_reg;
  wire               txf_valid;
  wire [DATA_W-1:0]  txf_data;
  wire               rxf_ready;
  wire               txf_in_ready;
  wire               rx_src_valid;
  wire [DATA_W-1:0]  rx_src_data;
  wire               tx_pcs_rst;
  wire               rx_pcs_rst;
  wire               tx_run;
  wire               loop_serial;
  wire               pins_driven;
  wire               rpt;
  serial_pins_t      pins;

  // Release counter step, shared by both directions
  function automatic logic [2:0] hold_next(input logic rst_in, input logic [2:0] cnt);
    if (rst_in)
      hold_next = HOLD_ZERO;
    else if (cnt != HOLD_DONE)
      hold_next = cnt + 3'h1;
    else
      hold_next = cnt;
  endfunction

  // Each direction stays in reset while held, then five clocks more
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_hold_reg <= HOLD_ZERO;
      rx_hold_reg <= HOLD_ZERO;
    end
    else
    begin
      tx_hold_reg <= hold_next(tx_side_reset, tx_hold_reg);
      rx_hold_reg <= hold_next(rx_side_reset, rx_hold_reg);
    end
  end

  // The coding layer is held in reset until the count completes
  assign tx_pcs_rst  = tx_side_reset | (tx_hold_reg != HOLD_DONE);
  assign rx_pcs_rst  = rx_side_reset | (rx_hold_reg != HOLD_DONE);
  assign tx_in_reset = tx_pcs_rst;
  assign rx_in_reset = rx_pcs_rst;

  // Sleep comes only from the transceiver's own input; the package pin
  // is accepted but deliberately left out of every path
  assign sleeping = transceiver_sleep;
  assign tx_run   = ~tx_pcs_rst & ~transceiver_sleep;

  // Mode is registered so a glitch on the select cannot split the paths
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      mode_reg <= LB_NORMAL;
    else if (loopback_sel <= LB_REPEATER)
      mode_reg <= loopback_sel;
  end

  assign rpt         = (mode_reg == LB_REPEATER);
  assign loop_serial = (mode_reg == LB_SERIAL_PRE) | (mode_reg == LB_SERIAL_POST);
  assign serial_loop_en = loop_serial;                  // off in parallel mode
  // Ready is withheld while repeating, so no user word is taken and then lost
  assign tx_ready = txf_in_ready & ~rpt;

  // Transmit FIFO, recentred by the transmit reset
  xcvr_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .flush    (tx_pcs_rst),
    .in_valid (tx_valid & ~rpt),
    .in_ready (txf_in_ready),
    .in_data  (tx_data),
    .out_valid(txf_valid),
    .out_ready(tx_run),
    .out_data (txf_data)
  );

  // Encoder stage; repeater mode takes the received word directly
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      enc_reg <= '0;
    else if (tx_pcs_rst)
      enc_reg <= '0;
    else if (rpt && line_rx_valid)
      enc_reg <= line_rx_data;
    else if (!rpt && txf_valid && tx_run)
      enc_reg <= txf_data;
  end
  assign line_tx_data = enc_reg;

  // Receive source: line data, or transmit words in parallel loopback
  assign rx_src_valid = (mode_reg == LB_PARALLEL) ? (txf_valid & tx_run) : line_rx_valid;
  assign rx_src_data  = (mode_reg == LB_PARALLEL) ? txf_data : line_rx_data;

  // Decoder stage; cleared by the receive reset
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dec_reg       <= '0;
      dec_valid_reg <= 1'b0;
    end
    else if (rx_pcs_rst || transceiver_sleep)
    begin
      dec_reg       <= '0;
      dec_valid_reg <= 1'b0;
    end
    else
    begin
      dec_reg       <= rx_src_data;
      dec_valid_reg <= rx_src_valid & ~rpt & rxf_ready; // user side bypassed
    end
  end

  // Receive elastic buffer, recentred by the receive reset
  xcvr_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .flush    (rx_pcs_rst),
    .in_valid (dec_valid_reg),
    .in_ready (rxf_ready),
    .in_data  (dec_reg),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data (rx_data)
  );

  // Analogue configuration: only system reset or a load touches it
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cfg_reg <= '0;
    else if (analog_cfg_load)
      cfg_reg <= analog_cfg_in;                         // no directional reset term
  end
  assign analog_cfg = cfg_reg;

  // Analogue pipeline heartbeat keeps toggling through directional resets
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pipe_reg <= 1'b0;
    else if (!transceiver_sleep)
      pipe_reg <= ~pipe_reg;
  end
  assign analog_pipe_tick = pipe_reg;

  // Pins are dropped in pre-driver loopback and while asleep
  assign pins_driven = (mode_reg != LB_SERIAL_PRE) & ~transceiver_sleep;

  // Registered pin levels; inhibit forces the positive leg low
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pos_reg <= 1'b0;
      neg_reg <= 1'b1;
    end
    else
    begin
      pos_reg <= tx_output_inhibit ? 1'b0 : serial_bit;
      neg_reg <= ~serial_bit;
    end
  end

  // Combinational inhibit keeps the low level from the very cycle it asserts
  assign pins.pos    = pos_reg & ~tx_output_inhibit;
  assign pins.neg    = neg_reg;
  assign pins.pos_oe = pins_driven;
  assign pins.neg_oe = pins_driven;

  assign serial_out_pos    = pins.pos;
  assign serial_out_neg    = pins.neg;
  assign serial_out_pos_oe = pins.pos_oe;
  assign serial_out_neg_oe = pins.neg_oe;

endmodule
